//--- inc/pixcv_regs.svh
// Constants for the pixel input conversion block
// Overview of operation
// - Mode field bits 4,1,0; zero means idle
// - Code 001 converts YUV pixels to RGB
// - Code 010 converts delta-YUV pixels to RGB
// - Code 011 stores 16-bit pixels unchanged
// - Code 111 stores two 8-bit pixels per word
// - Counter loads width times height at start
// - Counter decrements once per accepted entry word
// - Counter zero clears mode bits to normal
// - Reset clears whole mode register to zero
// - Change mode only while in normal mode; writes during a run are still taken
// - Swap bit exchanges bytes in active modes
`ifndef PIXCV_REGS_SVH
`define PIXCV_REGS_SVH
`define PIXCV_MODE_BIT2_POS 4
`define PIXCV_SWAP_POS 2
`define PIXCV_MODE_BIT1_POS 1
`define PIXCV_MODE_BIT0_POS 0
`define PIXCV_MODE_REG_RESET 16'h0000
`define PIXCV_DATA_W 16
`define PIXCV_SIZE_W 10
`define PIXCV_BUF_DEPTH 2
`endif

//--- inc/pixcv_pkg.sv
// Types for the pixel input conversion block
package pixcv_pkg;
   typedef enum logic [2:0] {
      PIXCV_NORMAL = 3'h0,
      PIXCV_YUV = 3'h1,
      PIXCV_DYUV = 3'h2,
      PIXCV_PASS16 = 3'h3,
      PIXCV_PRE8 = 3'h4,
      PIXCV_BAD5 = 3'h5,
      PIXCV_BAD6 = 3'h6,
      PIXCV_PASS8 = 3'h7
   } pixcv_mode_t;

   typedef enum logic [1:0] {
      PIXCV_IDLE = 2'h1,
      PIXCV_RUN = 2'h2
   } pixcv_state_t;
endpackage : pixcv_pkg

//--- rtl/pixcv_buf.sv
// Small valid/ready buffer between entry port and memory side
`timescale 1ns/1ps
module pixcv_buf #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 2
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
   localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wptr_reg;
   logic [PW-1:0] rptr_reg;
   logic [PW:0] fill_reg;
   wire push_w = in_valid_i && in_ready_o;
   wire pop_w = out_valid_o && out_ready_i;

   assign in_ready_o = (fill_reg != DEPTH_C);
   assign out_valid_o = (fill_reg != '0);
   assign out_data_o = mem[rptr_reg];

   always_ff @(posedge sys_clk_i) begin
      if (push_w) begin
         mem[wptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         fill_reg <= '0;
      end else begin
         if (push_w) begin
            wptr_reg <= (wptr_reg == LAST_C) ? '0 : wptr_reg + 1'b1;
         end
         if (pop_w) begin
            rptr_reg <= (rptr_reg == LAST_C) ? '0 : rptr_reg + 1'b1;
         end
         if (push_w && !pop_w) begin
            fill_reg <= fill_reg + 1'b1;
         end else if (pop_w && !push_w) begin
            fill_reg <= fill_reg - 1'b1;
         end
      end
   end
endmodule : pixcv_buf

//--- rtl/pixcv_top.sv
// Pixel input conversion mode control and entry data path
`timescale 1ns/1ps
`include "pixcv_regs.svh"
module pixcv_top #(
   parameter int DATA_W = `PIXCV_DATA_W,
   parameter int SIZE_W = `PIXCV_SIZE_W,
   parameter int BUF_DEPTH = `PIXCV_BUF_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Mode register write and read back
   input wire logic conv_mode_wr_i,
   input wire logic [15:0] conv_mode_wdata_i,
   output logic [15:0] conversion_mode_register_o,
   // Image size register fields
   input wire logic [SIZE_W-1:0] image_width_value_i,
   input wire logic [SIZE_W-1:0] image_height_value_i,
   // Image entry port
   input wire logic image_entry_port_valid_i,
   output logic image_entry_port_ready_o,
   input wire logic [DATA_W-1:0] image_entry_port_data_i,
   // Towards graphics memory
   output logic graphics_memory_valid_o,
   input wire logic graphics_memory_ready_i,
   output logic [DATA_W-1:0] graphics_memory_data_o,
   output logic [2:0] graphics_memory_fmt_o,
   // Status
   output logic conv_busy_o,
   output logic chip_select_zero_path_block_o,
   output logic [2*SIZE_W-1:0] pixel_count_o
);
   localparam int CNT_W = 2 * SIZE_W;
   localparam int BUF_W = DATA_W + 3;

   //----------------------------------------------------------------
   // Mode register
   //----------------------------------------------------------------
   logic conv_mode_bit2_reg;
   logic conv_mode_bit1_reg;
   logic conv_mode_bit0_reg;
   logic entry_byte_swap_reg;
   logic [CNT_W-1:0] pix_cnt_reg;
   pixcv_pkg::pixcv_state_t state_reg;
   pixcv_pkg::pixcv_state_t state_next;

   wire [2:0] wr_code_w = {conv_mode_wdata_i[`PIXCV_MODE_BIT2_POS],
                           conv_mode_wdata_i[`PIXCV_MODE_BIT1_POS],
                           conv_mode_wdata_i[`PIXCV_MODE_BIT0_POS]};
   wire [2:0] cur_code_w = {conv_mode_bit2_reg, conv_mode_bit1_reg, conv_mode_bit0_reg};
   pixcv_pkg::pixcv_mode_t cur_mode_w;
   assign cur_mode_w = pixcv_pkg::pixcv_mode_t'(cur_code_w);

   // Only four codes move data; idle, staging and forbidden codes do not
   function automatic logic code_active(input logic [2:0] code);
      logic act;
      act = 1'b0;
      case (pixcv_pkg::pixcv_mode_t'(code))
         pixcv_pkg::PIXCV_YUV: act = 1'b1;
         pixcv_pkg::PIXCV_DYUV: act = 1'b1;
         pixcv_pkg::PIXCV_PASS16: act = 1'b1;
         pixcv_pkg::PIXCV_PASS8: act = 1'b1;
         default: act = 1'b0;
      endcase
      return act;
   endfunction : code_active

   //----------------------------------------------------------------
   // Write decode
   //----------------------------------------------------------------
   wire wr_active_w = code_active(wr_code_w);
   wire running_w = (state_reg == pixcv_pkg::PIXCV_RUN);
   // Active code loads the count; any other code stops a run
   wire wr_load_w = conv_mode_wr_i && wr_active_w;
   wire wr_stop_w = conv_mode_wr_i && !wr_active_w;

   //----------------------------------------------------------------
   // Entry path selection
   //----------------------------------------------------------------
   // Words count down as they are taken, not as memory drains
   logic buf_in_ready;
   wire accept_w = running_w && image_entry_port_valid_i && buf_in_ready;
   wire last_pix_w = accept_w && (pix_cnt_reg == CNT_W'(1));
   wire zero_cnt_w = running_w && (pix_cnt_reg == '0);
   wire done_w = last_pix_w || zero_cnt_w;
   // Size inputs only matter on the load write
   wire [CNT_W-1:0] total_w = CNT_W'(image_width_value_i * image_height_value_i);

   // In normal mode words are taken and dropped so the host never hangs
   assign image_entry_port_ready_o = running_w ? buf_in_ready : 1'b1;

   // Byte exchange of each entry word when enabled
   logic [DATA_W-1:0] swapped_w;
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W / 8; gi++) begin : g_lane
         assign swapped_w[gi*8 +: 8] = image_entry_port_data_i[(DATA_W/8-1-gi)*8 +: 8];
      end
   endgenerate
   wire [DATA_W-1:0] entry_word_w = (entry_byte_swap_reg && running_w) ?
                                    swapped_w : image_entry_port_data_i;

   //----------------------------------------------------------------
   // Format tag
   //----------------------------------------------------------------
   // Format tag steers the colour stage downstream: YUV and delta-YUV get
   // converted to RGB, pass-through codes keep the word as is.
   wire [2:0] fmt_w = cur_mode_w;
   wire [BUF_W-1:0] buf_in_w = {fmt_w, entry_word_w};
   logic [BUF_W-1:0] buf_out;

   //----------------------------------------------------------------
   // State machine
   //----------------------------------------------------------------
   // Idle until an active code is written
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pixcv_pkg::PIXCV_IDLE: begin
            if (wr_load_w) begin
               state_next = pixcv_pkg::PIXCV_RUN;
            end
         end
         pixcv_pkg::PIXCV_RUN: begin
            // A host rewrite outranks the end of count
            if (wr_stop_w) begin
               state_next = pixcv_pkg::PIXCV_IDLE;
            end else if (wr_load_w) begin
               state_next = pixcv_pkg::PIXCV_RUN;
            end else if (done_w) begin
               state_next = pixcv_pkg::PIXCV_IDLE;
            end
         end
         default: begin
            state_next = pixcv_pkg::PIXCV_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= pixcv_pkg::PIXCV_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   //----------------------------------------------------------------
   // Mode bits
   //----------------------------------------------------------------
   // Rewriting an active code during a run reloads the count; result is left to the host
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_mode_bit2_reg <= 1'b0;
         conv_mode_bit1_reg <= 1'b0;
         conv_mode_bit0_reg <= 1'b0;
         entry_byte_swap_reg <= 1'b0;
      end else if (conv_mode_wr_i) begin
         conv_mode_bit2_reg <= wr_code_w[2];
         conv_mode_bit1_reg <= wr_code_w[1];
         conv_mode_bit0_reg <= wr_code_w[0];
         entry_byte_swap_reg <= conv_mode_wdata_i[`PIXCV_SWAP_POS];
      end else if (done_w) begin
         // Swap bit survives the self-clear
         conv_mode_bit2_reg <= 1'b0;
         conv_mode_bit1_reg <= 1'b0;
         conv_mode_bit0_reg <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // Pixel counter
   //----------------------------------------------------------------
   // In 8-bit pass-through one word is one count, width holds words
   // Count rests at zero; a zero product ends the run on the next edge
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pix_cnt_reg <= '0;
      end else if (wr_load_w) begin
         pix_cnt_reg <= total_w;
      end else if (accept_w && (pix_cnt_reg != '0)) begin
         pix_cnt_reg <= pix_cnt_reg - CNT_W'(1);
      end
   end

   //----------------------------------------------------------------
   // Buffer towards graphics memory
   //----------------------------------------------------------------
   // Two entries keep every taken word through a memory stall
   pixcv_buf #(
      .WIDTH(BUF_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .in_valid_i(accept_w),
      .in_ready_o(buf_in_ready),
      .in_data_i(buf_in_w),
      .out_valid_o(graphics_memory_valid_o),
      .out_ready_i(graphics_memory_ready_i),
      .out_data_o(buf_out)
   );

   assign graphics_memory_data_o = buf_out[DATA_W-1:0];
   assign graphics_memory_fmt_o = buf_out[BUF_W-1:DATA_W];

   //----------------------------------------------------------------
   // Readback
   //----------------------------------------------------------------
   always_comb begin
      conversion_mode_register_o = `PIXCV_MODE_REG_RESET;
      conversion_mode_register_o[`PIXCV_MODE_BIT2_POS] = conv_mode_bit2_reg;
      conversion_mode_register_o[`PIXCV_SWAP_POS] = entry_byte_swap_reg;
      conversion_mode_register_o[`PIXCV_MODE_BIT1_POS] = conv_mode_bit1_reg;
      conversion_mode_register_o[`PIXCV_MODE_BIT0_POS] = conv_mode_bit0_reg;
   end

   //----------------------------------------------------------------
   // Status
   //----------------------------------------------------------------
   // Memory path stays blocked until the buffer drains
   assign conv_busy_o = running_w;
   assign chip_select_zero_path_block_o = running_w || graphics_memory_valid_o;
   assign pixel_count_o = pix_cnt_reg;
endmodule : pixcv_top

//--- tb/pixcv_top_properties.sv
// Port-level assertions for the pixel conversion block
`timescale 1ns/1ps
module pixcv_top_properties #(
   parameter int DATA_W = 16,
   parameter int SIZE_W = 10
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic conv_mode_wr_i,
   input wire logic [15:0] conv_mode_wdata_i,
   input wire logic [15:0] conversion_mode_register_o,
   input wire logic [SIZE_W-1:0] image_width_value_i,
   input wire logic [SIZE_W-1:0] image_height_value_i,
   input wire logic image_entry_port_valid_i,
   input wire logic image_entry_port_ready_o,
   input wire logic [DATA_W-1:0] image_entry_port_data_i,
   input wire logic graphics_memory_valid_o,
   input wire logic graphics_memory_ready_i,
   input wire logic [DATA_W-1:0] graphics_memory_data_o,
   input wire logic [2:0] graphics_memory_fmt_o,
   input wire logic conv_busy_o,
   input wire logic chip_select_zero_path_block_o,
   input wire logic [2*SIZE_W-1:0] pixel_count_o
);
   wire [2:0] wcode = {conv_mode_wdata_i[4], conv_mode_wdata_i[1:0]};
   wire [2:0] rcode = {conversion_mode_register_o[4], conversion_mode_register_o[1:0]};
   wire take = image_entry_port_valid_i && image_entry_port_ready_o && conv_busy_o
      && !conv_mode_wr_i;
   wire [15:0] xd = conversion_mode_register_o[2] ?
      {image_entry_port_data_i[7:0], image_entry_port_data_i[15:8]} : image_entry_port_data_i;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   reset_clear_a: assert property ($fell(rst_i) |-> conversion_mode_register_o == 16'h0000
      && !conv_busy_o) else $error("mode not clear after reset");
   mode_load_a: assert property (conv_mode_wr_i && wcode inside {3'h1, 3'h2, 3'h3, 3'h7}
      |=> conv_busy_o && pixel_count_o == $past(image_width_value_i) * $past(image_height_value_i))
      else $error("count not loaded");
   mode_readback_a: assert property (conv_mode_wr_i |=>
      conversion_mode_register_o == ($past(conv_mode_wdata_i) & 16'h0017)) else $error("readback");
   idle_drop_a: assert property (!conv_busy_o |-> image_entry_port_ready_o)
      else $error("entry stalled in normal mode");
   count_dec_a: assert property (take && pixel_count_o > 1 |=> conv_busy_o
      && pixel_count_o == $past(pixel_count_o) - 1) else $error("count not decremented");
   self_clear_a: assert property (take && pixel_count_o == 1 |=> !conv_busy_o
      && rcode == 3'h0) else $error("mode not self-cleared");
   zero_size_a: assert property (conv_busy_o && pixel_count_o == 0 && !conv_mode_wr_i
      |=> !conv_busy_o) else $error("zero count kept busy");
   swap_data_a: assert property (take && !graphics_memory_valid_o |=> graphics_memory_valid_o
      && graphics_memory_data_o == $past(xd) && graphics_memory_fmt_o == $past(rcode))
      else $error("stored word wrong");
   out_hold_a: assert property (graphics_memory_valid_o && !graphics_memory_ready_i
      |=> graphics_memory_valid_o && $stable(graphics_memory_data_o)) else $error("word lost");
   cs_block_a: assert property (conv_busy_o |-> chip_select_zero_path_block_o)
      else $error("path not blocked");
   cover property (take && pixel_count_o == 1);
   cover property (conv_busy_o && !image_entry_port_ready_o);
   cover property (conv_mode_wr_i && wcode == 3'h7);
endmodule : pixcv_top_properties

bind pixcv_top pixcv_top_properties #(.DATA_W(DATA_W), .SIZE_W(SIZE_W)) chk_i (.*);

//--- tb/pixcv_mem_sink.sv
// Graphics memory side model that can stall
`timescale 1ns/1ps
module pixcv_mem_sink (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic valid_i,
   input wire logic [15:0] data_i,
   input wire logic [2:0] fmt_i,
   output logic ready_o
);
   logic [1:0] ph_reg;
   logic [18:0] mem [0:31];
   int got;
   // Slow mode accepts one cycle in four
   assign ready_o = !slow_i || ph_reg == 2'h3;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ph_reg <= 2'h0;
         got <= 0;
      end else begin
         ph_reg <= ph_reg + 2'h1;
         if (valid_i && ready_o) begin
            mem[got] <= {fmt_i, data_i};
            got <= got + 1;
         end
      end
   end
endmodule : pixcv_mem_sink

//--- tb/pixcv_top_tb.sv
// Self-checking bench for the pixel conversion block
`timescale 1ns/1ps
module pixcv_top_tb;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wr = 1'b0, iv = 1'b0, slow = 1'b0;
   logic [15:0] wd = 16'h0000, id = 16'h0000;
   logic [9:0] w = 10'h000, h = 10'h000;
   logic ir, mv, mr, busy, csb;
   logic [15:0] reg_o, md;
   logic [2:0] mf;
   logic [19:0] cnt;
   int err_count = 0, checked = 0, k = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   pixcv_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .conv_mode_wr_i(wr),
      .conv_mode_wdata_i(wd), .conversion_mode_register_o(reg_o), .image_width_value_i(w),
      .image_height_value_i(h), .image_entry_port_valid_i(iv), .image_entry_port_ready_o(ir),
      .image_entry_port_data_i(id), .graphics_memory_valid_o(mv), .graphics_memory_ready_i(mr),
      .graphics_memory_data_o(md), .graphics_memory_fmt_o(mf), .conv_busy_o(busy),
      .chip_select_zero_path_block_o(csb), .pixel_count_o(cnt));
   pixcv_mem_sink sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow), .valid_i(mv),
      .data_i(md), .fmt_i(mf), .ready_o(mr));
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic print_verdict;
      if (err_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task automatic mode_wr(input logic [2:0] c, input logic s, input logic [9:0] ww);
      @(negedge sys_clk_i);
      wr = 1'b1;
      wd = {11'h000, c[2], 1'b0, s, c[1:0]};
      w = ww;
      h = 10'h002;
      @(negedge sys_clk_i);
      wr = 1'b0;
      chk("mode_reg", {4'h0, wd}, {4'h0, reg_o});
   endtask : mode_wr
   task automatic push(input logic [15:0] d, input logic [19:0] e);
      int n = 0;
      @(negedge sys_clk_i);
      chk("count", e, cnt);
      iv = 1'b1;
      id = d;
      while (!ir && n < 64) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk("entry_ready", 20'h1, {19'h0, ir});
      @(posedge sys_clk_i);
   endtask : push
   task automatic t_reset;
      @(negedge sys_clk_i);
      chk("rst_reg", 20'h0, {4'h0, reg_o});
      chk("rst_flags", 20'h1, {17'h0, busy, mv, ir});
   endtask : t_reset
   task automatic t_idle;
      push(16'hdead, 20'h0);
      @(negedge sys_clk_i);
      iv = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk("idle_out", 20'h0, {18'h0, mv, busy});
   endtask : t_idle
   task automatic t_run(input logic [2:0] c, input logic s, input logic [2:0] pre);
      logic [15:0] d;
      mode_wr(pre, 1'b0, 10'h002);
      mode_wr(c, s, 10'h002);
      chk("busy", 20'h1, {19'h0, busy});
      chk("cs_block", 20'h1, {19'h0, csb});
      for (int i = 0; i < 4; i++) push(16'h1200 + 16'(k + i), 20'(4 - i));
      @(negedge sys_clk_i);
      iv = 1'b0;
      chk("end_busy", 20'h0, {19'h0, busy});
      chk("end_reg", {17'h0, s, 2'h0}, {4'h0, reg_o});
      for (int n = 0; n < 99 && sink.got < k + 4; n++) @(negedge sys_clk_i);
      chk("cs_free", 20'h0, {19'h0, csb});
      for (int i = k; i < k + 4; i++) begin
         d = 16'h1200 + 16'(i);
         chk("stored", {1'b0, c, s ? {d[7:0], d[15:8]} : d}, {1'b0, sink.mem[i]});
      end
      k += 4;
   endtask : t_run
   task automatic t_zero;
      mode_wr(3'h1, 1'b0, 10'h000);
      @(negedge sys_clk_i);
      chk("zero_busy", 20'h0, {19'h0, busy});
   endtask : t_zero
   initial begin
      repeat (2) @(negedge sys_clk_i);
      rst_i = 1'b0;
      t_reset();
      t_idle();
      t_run(3'h1, 1'b0, 3'h0);
      t_run(3'h2, 1'b1, 3'h0);
      t_run(3'h3, 1'b1, 3'h0);
      slow = 1'b1;
      t_run(3'h7, 1'b0, 3'h4);
      t_zero();
      print_verdict();
   end
   initial begin
      #20000;
      err_count++;
      print_verdict();
   end
endmodule : pixcv_top_tb
